/* src/rsc_pkg.sv */
// rsc_pkg: constants, types and register map of the reset and strap configuration block
// assumes a 200 MHz core clock and an APB register port with 8 address bits
`default_nettype none
package rsc_pkg;
  // timing
  localparam int CLK_MHZ      = 200;
  localparam int MEM_INIT_NS  = 100;                                  // memory init settle time
  localparam int MEM_INIT_CYC = (MEM_INIT_NS * CLK_MHZ + 999) / 1000; // least time, rounded up
  localparam logic [7:0] MEM_INIT_CNT = 8'(MEM_INIT_CYC);

  // register byte offsets
  localparam logic [7:0] OFF_CTRL      = 8'h00;
  localparam logic [7:0] OFF_STATUS    = 8'h04;
  localparam logic [7:0] OFF_STRAP_EXP = 8'h08;
  localparam logic [7:0] OFF_STRAP_MEM = 8'h0c;
  localparam logic [7:0] OFF_MEM_KHZ   = 8'h10;
  localparam logic [7:0] OFF_PROC_KHZ  = 8'h14;

  // control register bits
  localparam int CTL_FW_RESET   = 0;
  localparam int CTL_PERIPH_RST = 1;
  localparam int CTL_SCREEN_REF = 2;
  localparam int CTL_VIDEO_OUT  = 3;
  localparam int CTL_INSTRUCTION_CACHE_EN  = 4;
  localparam int CTL_DCACHE_OFF = 5;
  localparam int CTL_EXT_MODE   = 6;
  localparam int CTL_W          = 7;
  localparam logic [CTL_W-1:0] CTL_RESET = 7'h00;

  // strap positions on the memory data pins
  localparam int MD_RATE     = 29;  // two bits
  localparam int MD_KIND     = 33;
  localparam int MD_CAS      = 35;
  localparam int MD_BANK0    = 38;  // three bits
  localparam int MD_BANK1    = 41;  // three bits
  localparam int MD_INTBANKS = 44;
  localparam int MD_PERMUTE  = 61;  // two bits

  // strap positions on the expansion pins
  localparam int XD_PROC   = 0;     // four bits
  localparam int XD_TEST_N = 4;
  localparam int XD_PLL    = 5;
  localparam int XD_ROLE   = 6;     // two bits
  localparam int XA_DAC    = 0;
  localparam int XA_SCLK   = 1;
  localparam int XA_PCLK   = 2;
  localparam int XA_PLLCHK = 3;

  localparam logic [31:0] RESET_PC = 32'hfffffff0;

  // clock rates in kHz
  localparam logic [16:0] KHZ_125000 = 17'h1e848;
  localparam logic [16:0] KHZ_100000 = 17'h186a0;
  localparam logic [16:0] KHZ_90000  = 17'h15f90;
  localparam logic [16:0] KHZ_83330  = 17'h14582;
  localparam logic [16:0] KHZ_75000  = 17'h124f8;
  localparam logic [16:0] KHZ_66670  = 17'h1046e;
  localparam logic [16:0] KHZ_60000  = 17'h0ea60;
  localparam logic [16:0] KHZ_55600  = 17'h0d930;
  localparam logic [16:0] KHZ_50000  = 17'h0c350;

  typedef enum logic [2:0] {
    RSC_ST_HARD = 3'b001,
    RSC_ST_SOFT = 3'b010,
    RSC_ST_RUN  = 3'b100
  } rsc_state_e;

  typedef enum logic [1:0] {
    RSC_ROLE_OTHER = 2'h0,
    RSC_ROLE_MEDIA = 2'h1,
    RSC_ROLE_VGA   = 2'h2
  } rsc_role_e;

  typedef struct packed {
    logic [1:0] memory_clock_rate_strap;
    logic       memory_kind_strap;
    logic       memory_cas_delay_strap;
    logic [2:0] bank0_capacity_strap;
    logic [2:0] bank1_capacity_strap;
    logic       internal_bank_count_strap;
    logic [1:0] address_permute_strap;
  } rsc_mem_cfg_s;

  typedef struct packed {
    rsc_mem_cfg_s mem;
    logic [3:0]   processor_clock_limit_strap;
    logic         test_mode;
    logic         pll_run_strap;
    rsc_role_e    display_role;
    logic         dac_from_video_in;
    logic         dac_from_test_counter;
    logic         system_clock_from_pll;
    logic         pixel_clock_from_pll;
    logic         pll_analog_check;
    logic         clock_test_state;
  } rsc_cfg_s;
endpackage : rsc_pkg
`default_nettype wire

/* src/rsc_reset_strap.sv */
// rsc_reset_strap: reset sequencing, strap capture and decode, peripheral reset output
// assumes all inputs synchronous to clk; straps are driven by board resistors during reset
//
// The register addresses and the APB slave port were decided locally.
`default_nettype none

////////////////////////////////////////////////////////////////////////////////
// Notes on behaviour
// - expansion data and low address straps are sampled in hardware reset only.
// - hardware reset initialises memory controller and starts refresh; soft reset does not.
// - any reset restores internal state; soft reset leaves PCI logic alone.
// - hardware or soft reset empties every internal FIFO.
// - reset invalidates and enables the data cache, turns the instruction cache off.
// - reset disables screen refresh requests and turns video outputs off.
// - after hardware reset VGA mode if strapped as VGA, otherwise native mode.
// - reset loads the processor program counter with the boot ROM address.
// - reset places the device in predecessor compatibility mode.
// - memory rate strap 3..0 selects 125/100/83.33/66.67 MHz when PLL runs.
// - memory kind, latency, bank sizes, banks per chip, permute come from straps.
// - processor strap 15 selects 50 MHz, down to 9 selecting 90 MHz.
// - test strap is active low: 1 normal, 0 test mode.
// - PLL run strap: 1 runs from PLL, 0 uses direct clocks.
// - in test mode DAC strap picks video input bus or internal test counter.
// - system and pixel clock source straps; PLL analog check strap active low.
// - upper address straps all 0 with PLL run 1 enters clock test state.
// - host holds PCI reset 3 PCI clocks; device resets and asserts peripheral reset.
// - active-low peripheral reset output resets the expansion bus devices.
module rsc_reset_strap (
  // clock and reset
  input  wire logic                  clk,
  input  wire logic                  sys_rst,
  // reset sources
  input  wire logic                  hw_reset_in,
  input  wire logic                  pci_rst_n,
  // strap pins (input side of the shared pins)
  input  wire logic [7:0]            expansion_data_pins,
  input  wire logic [3:0]            expansion_address_pins,
  input  wire logic [63:0]           memory_data_pins,
  // apb slave
  input  wire logic                  psel,
  input  wire logic                  penable,
  input  wire logic                  pwrite,
  input  wire logic [7:0]            paddr,
  input  wire logic [31:0]           pwdata,
  output logic                       pready,
  output logic [31:0]                prdata,
  output logic                       pslverr,
  // reset controls to internal units
  output logic                       core_state_rst,
  output logic                       pci_logic_rst,
  output logic                       fifo_flush,
  output logic                       dcache_invalidate,
  output logic                       dcache_enable,
  output logic                       instruction_cache_enable,
  output logic                       screen_refresh_en,
  output logic                       video_out_en,
  output logic                       mem_ctrl_init,
  output logic                       mem_refresh_en,
  output logic                       vga_mode,
  output logic                       compat_mode,
  output logic                       proc_hold,
  output logic [31:0]                proc_pc,
  // peripheral reset and decoded configuration
  output logic                       peripheral_reset_out_n,
  output rsc_pkg::rsc_cfg_s          cfg,
  output logic [16:0]                mem_clock_khz,
  output logic                       mem_clock_valid,
  output logic [16:0]                proc_clock_khz
);
  import rsc_pkg::*;

  ////////////////////////////////////////////////////////////////////////////////
  // decode helpers

  function automatic logic [16:0] mem_rate_khz(input logic [1:0] code);
    case (code)
      2'h3:    mem_rate_khz = KHZ_125000;
      2'h2:    mem_rate_khz = KHZ_100000;
      2'h1:    mem_rate_khz = KHZ_83330;
      default: mem_rate_khz = KHZ_66670;
    endcase
  endfunction : mem_rate_khz

  // codes below 9 have no defined rate and read as zero
  function automatic logic [16:0] proc_rate_khz(input logic [3:0] code);
    case (code)
      4'hf:    proc_rate_khz = KHZ_50000;
      4'he:    proc_rate_khz = KHZ_55600;
      4'hd:    proc_rate_khz = KHZ_60000;
      4'hc:    proc_rate_khz = KHZ_66670;
      4'hb:    proc_rate_khz = KHZ_75000;
      4'ha:    proc_rate_khz = KHZ_83330;
      4'h9:    proc_rate_khz = KHZ_90000;
      default: proc_rate_khz = 17'h00000;
    endcase
  endfunction : proc_rate_khz

  function automatic rsc_role_e role_of(input logic [1:0] code);
    case (code)
      2'h3, 2'h2: role_of = RSC_ROLE_VGA;
      2'h1:       role_of = RSC_ROLE_MEDIA;
      default:    role_of = RSC_ROLE_OTHER;
    endcase
  endfunction : role_of

  ////////////////////////////////////////////////////////////////////////////////
  // reset sources

  logic             hard_req;
  logic             apb_wr;
  logic [CTL_W-1:0] ctrl_r;
  rsc_state_e       state_r;
  rsc_state_e       state_nxt;
  logic             in_reset;
  logic [7:0]       init_cnt_r;
  logic             init_busy_r;
  logic [11:0]      strap_exp_r;

  // a pci reset of any length counts as a hardware reset
  assign hard_req = hw_reset_in | ~pci_rst_n;
  assign apb_wr   = psel & penable & pready & pwrite;
  assign in_reset = (state_nxt != RSC_ST_RUN);

  ////////////////////////////////////////////////////////////////////////////////
  // sequencer state

  // hardware reset overrides a soft reset in progress
  always_comb begin
    case (state_r)
      RSC_ST_HARD: state_nxt = hard_req ? RSC_ST_HARD : RSC_ST_RUN;
      RSC_ST_SOFT: begin
        if (hard_req) state_nxt = RSC_ST_HARD;
        else if (!ctrl_r[CTL_FW_RESET]) state_nxt = RSC_ST_RUN;
        else state_nxt = RSC_ST_SOFT;
      end
      RSC_ST_RUN: begin
        if (hard_req) state_nxt = RSC_ST_HARD;
        else if (ctrl_r[CTL_FW_RESET]) state_nxt = RSC_ST_SOFT;
        else state_nxt = RSC_ST_RUN;
      end
      default: state_nxt = RSC_ST_HARD;
    endcase
  end

  always_ff @(posedge clk) begin
    if (sys_rst) state_r <= RSC_ST_HARD;
    else state_r <= state_nxt;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // control register

  // the soft reset keeps its own trigger and the peripheral reset bit, so that
  // software can time both; every other control bit returns to its default
  always_ff @(posedge clk) begin
    if (sys_rst || state_r == RSC_ST_HARD) begin
      ctrl_r <= CTL_RESET;
    end else if (apb_wr && paddr == OFF_CTRL) begin
      ctrl_r <= pwdata[CTL_W-1:0];
    end else if (state_r == RSC_ST_SOFT) begin
      ctrl_r[CTL_SCREEN_REF] <= 1'b0;
      ctrl_r[CTL_VIDEO_OUT]  <= 1'b0;
      ctrl_r[CTL_INSTRUCTION_CACHE_EN]  <= 1'b0;
      ctrl_r[CTL_DCACHE_OFF] <= 1'b0;
      ctrl_r[CTL_EXT_MODE]   <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // strap capture

  // straps follow the pins throughout hardware reset and freeze at its release;
  // soft resets never touch them
  always_ff @(posedge clk) begin
    if (state_r == RSC_ST_HARD) begin
      strap_exp_r <= {expansion_address_pins, expansion_data_pins};
      cfg.mem.memory_clock_rate_strap   <= memory_data_pins[MD_RATE+1:MD_RATE];
      cfg.mem.memory_kind_strap         <= memory_data_pins[MD_KIND];
      cfg.mem.memory_cas_delay_strap    <= memory_data_pins[MD_CAS];
      cfg.mem.bank0_capacity_strap      <= memory_data_pins[MD_BANK0+2:MD_BANK0];
      cfg.mem.bank1_capacity_strap      <= memory_data_pins[MD_BANK1+2:MD_BANK1];
      cfg.mem.internal_bank_count_strap <= memory_data_pins[MD_INTBANKS];
      cfg.mem.address_permute_strap     <= memory_data_pins[MD_PERMUTE+1:MD_PERMUTE];
      cfg.processor_clock_limit_strap   <= expansion_data_pins[XD_PROC+3:XD_PROC];
      cfg.test_mode                     <= ~expansion_data_pins[XD_TEST_N];
      cfg.pll_run_strap                 <= expansion_data_pins[XD_PLL];
      cfg.display_role                  <= role_of(expansion_data_pins[XD_ROLE+1:XD_ROLE]);
      cfg.dac_from_video_in     <= ~expansion_data_pins[XD_TEST_N] &
                                   expansion_address_pins[XA_DAC];
      cfg.dac_from_test_counter <= ~expansion_data_pins[XD_TEST_N] &
                                   ~expansion_address_pins[XA_DAC];
      cfg.system_clock_from_pll <= expansion_address_pins[XA_SCLK];
      cfg.pixel_clock_from_pll  <= expansion_address_pins[XA_PCLK];
      cfg.pll_analog_check      <= ~expansion_address_pins[XA_PLLCHK];
      cfg.clock_test_state      <= (expansion_address_pins[3:1] == 3'h0) &
                                   expansion_data_pins[XD_PLL];
    end
  end

  // decoded rates, taken from the held straps one cycle later
  always_ff @(posedge clk) begin
    mem_clock_khz   <= mem_rate_khz(cfg.mem.memory_clock_rate_strap);
    mem_clock_valid <= cfg.pll_run_strap;
    proc_clock_khz  <= proc_rate_khz(cfg.processor_clock_limit_strap);
  end

  ////////////////////////////////////////////////////////////////////////////////
  // memory controller initialisation

  // only a hardware reset restarts init; refresh starts once init settles
  always_ff @(posedge clk) begin
    if (sys_rst || state_r == RSC_ST_HARD) begin
      init_cnt_r     <= MEM_INIT_CNT;
      init_busy_r    <= 1'b1;
      mem_ctrl_init  <= 1'b1;
      mem_refresh_en <= 1'b0;
    end else if (init_busy_r) begin
      mem_ctrl_init <= 1'b1;
      if (init_cnt_r == 8'h01) begin
        init_busy_r    <= 1'b0;
        mem_ctrl_init  <= 1'b0;
        mem_refresh_en <= 1'b1;
      end
      init_cnt_r <= init_cnt_r - 8'h01;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // unit reset controls

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      core_state_rst    <= 1'b1;
      pci_logic_rst     <= 1'b1;
      fifo_flush        <= 1'b1;
      dcache_invalidate <= 1'b1;
    end else begin
      core_state_rst    <= (state_nxt != RSC_ST_RUN);
      pci_logic_rst     <= (state_nxt == RSC_ST_HARD);
      fifo_flush        <= (state_nxt != RSC_ST_RUN);
      dcache_invalidate <= (state_nxt != RSC_ST_RUN);
    end
  end

  // enables follow the next state, so they drop in step with core_state_rst
  always_ff @(posedge clk) begin
    if (sys_rst || in_reset) begin
      dcache_enable     <= 1'b1;
      instruction_cache_enable     <= 1'b0;
      screen_refresh_en <= 1'b0;
      video_out_en      <= 1'b0;
      compat_mode       <= 1'b1;
    end else begin
      dcache_enable     <= ~ctrl_r[CTL_DCACHE_OFF];
      instruction_cache_enable     <= ctrl_r[CTL_INSTRUCTION_CACHE_EN];
      screen_refresh_en <= ctrl_r[CTL_SCREEN_REF];
      video_out_en      <= ctrl_r[CTL_VIDEO_OUT];
      compat_mode       <= ~ctrl_r[CTL_EXT_MODE];
    end
  end

  // processor waits at the boot vector while any reset lasts
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      proc_hold <= 1'b1;
      proc_pc   <= RESET_PC;
    end else begin
      proc_hold <= (state_nxt != RSC_ST_RUN);
      proc_pc   <= RESET_PC;
    end
  end

  // the display mode is chosen on leaving reset: the strap counts only after a
  // hardware reset, a soft reset always comes back in native mode
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      vga_mode <= 1'b0;
    end else if (state_r == RSC_ST_HARD && state_nxt == RSC_ST_RUN) begin
      vga_mode <= (cfg.display_role == RSC_ROLE_VGA);
    end else if (state_r == RSC_ST_SOFT) begin
      vga_mode <= 1'b0;
    end
  end

  // expansion bus peripherals are held in reset by hardware reset or by the
  // dedicated software bit, never by the plain soft reset
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      peripheral_reset_out_n <= 1'b0;
    end else begin
      peripheral_reset_out_n <= ~(hard_req | (state_r == RSC_ST_HARD) |
                                  ctrl_r[CTL_PERIPH_RST]);
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // apb slave

  // one wait state: pready rises in the second access cycle, which keeps the
  // read mux off the bus path at the cost of one cycle per transfer
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      pready  <= 1'b0;
      prdata  <= 32'h00000000;
      pslverr <= 1'b0;
    end else if (psel && penable && !pready) begin
      pready  <= 1'b1;
      pslverr <= 1'b0;
      prdata  <= 32'h00000000;
      case (paddr)
        OFF_CTRL:      prdata <= {25'h0000000, ctrl_r};
        OFF_STATUS:    prdata <= {24'h000000, init_busy_r, compat_mode, ~peripheral_reset_out_n,
                                  mem_refresh_en, vga_mode, 3'(state_r)};
        OFF_STRAP_EXP: prdata <= {20'h00000, expansion_address_pins_q(), 8'h00} |
                                 {24'h000000, strap_xd_q()};
        OFF_STRAP_MEM: prdata <= {19'h00000, cfg.mem};
        OFF_MEM_KHZ:   prdata <= {14'h0000, mem_clock_valid, mem_clock_khz};
        OFF_PROC_KHZ:  prdata <= {15'h0000, proc_clock_khz};
        default:       pslverr <= 1'b1;
      endcase
    end else begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end
  end

  // raw straps as captured: the decodes lose role code 3 and the dac bit
  function automatic logic [3:0] expansion_address_pins_q();
    expansion_address_pins_q = strap_exp_r[11:8];
  endfunction : expansion_address_pins_q

  function automatic logic [7:0] strap_xd_q();
    strap_xd_q = strap_exp_r[7:0];
  endfunction : strap_xd_q

endmodule : rsc_reset_strap
`default_nettype wire

/* tb/rsc_chk.sv */
// rsc_chk: timing checks on the reset and strap configuration block
// assumes one clock domain and a synchronous active high sys_rst
`default_nettype none
module rsc_chk (
  // clock and reset
  input wire logic              clk,
  input wire logic              sys_rst,
  // reset sources
  input wire logic              hw_reset_in,
  input wire logic              pci_rst_n,
  // reset controls
  input wire logic              core_state_rst,
  input wire logic              pci_logic_rst,
  input wire logic              fifo_flush,
  input wire logic              dcache_invalidate,
  input wire logic              dcache_enable,
  input wire logic              instruction_cache_enable,
  input wire logic              screen_refresh_en,
  input wire logic              video_out_en,
  input wire logic              mem_refresh_en,
  input wire logic [31:0]       proc_pc,
  // peripheral reset and configuration
  input wire logic              peripheral_reset_out_n,
  input wire rsc_pkg::rsc_cfg_s cfg,
  input wire logic              mem_clock_valid
);
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  ////////////////////////////////////////////////////////////////////////////////
  property p_hw_prst; hw_reset_in |=> !peripheral_reset_out_n; endproperty
  a_hw_prst: assert property (p_hw_prst) else $error("peripheral reset missed");
  property p_pci; !pci_rst_n [*2] |=> pci_logic_rst && !peripheral_reset_out_n; endproperty
  a_pci: assert property (p_pci) else $error("pci reset not applied");
  property p_hw_units;
    hw_reset_in [*2] |=> core_state_rst && !mem_refresh_en && proc_pc == 32'hfffffff0;
  endproperty
  a_hw_units: assert property (p_hw_units) else $error("hard reset outputs wrong");
  property p_any;
    core_state_rst |-> fifo_flush && dcache_invalidate && dcache_enable && !instruction_cache_enable;
  endproperty
  a_any: assert property (p_any) else $error("fifo or cache state wrong in reset");
  property p_video; core_state_rst |-> !screen_refresh_en && !video_out_en; endproperty
  a_video: assert property (p_video) else $error("video active in reset");
  // soft reset must leave refresh running
  property p_soft; core_state_rst && !pci_logic_rst && mem_refresh_en |=> mem_refresh_en;
  endproperty
  a_soft: assert property (p_soft) else $error("refresh lost in soft reset");
  // decodes settle a few cycles after release, hence three cycles of margin
  property p_strap; peripheral_reset_out_n [*3] |-> $stable(cfg); endproperty
  a_strap: assert property (p_strap) else $error("straps changed outside reset");
  property p_dac;
    peripheral_reset_out_n [*3] |-> (cfg.dac_from_video_in || cfg.dac_from_test_counter)
      == cfg.test_mode && !(cfg.dac_from_video_in && cfg.dac_from_test_counter);
  endproperty
  a_dac: assert property (p_dac) else $error("dac source decode wrong");
  property p_mclk;
    peripheral_reset_out_n [*3] |-> mem_clock_valid == cfg.pll_run_strap
      && (!cfg.clock_test_state || cfg.pll_run_strap);
  endproperty
  a_mclk: assert property (p_mclk) else $error("pll strap use wrong");
  c_hw: cover property (hw_reset_in ##1 !hw_reset_in);
  c_pci: cover property (!pci_rst_n ##1 pci_rst_n);
  c_soft: cover property (core_state_rst && !pci_logic_rst);
endmodule : rsc_chk
bind rsc_reset_strap rsc_chk chk_u (.*);
`default_nettype wire

/* tb/rsc_board_model.sv */
// rsc_board_model: strap resistors and host reset drivers
// assumes go is a one cycle command; pins show straps only around reset
`default_nettype none
module rsc_board_model #(
  parameter int HW_HOLD  = 40,  // stands in for 100 ms to keep the run short
  parameter int PCI_HOLD = 18   // three 33 MHz periods in 200 MHz cycles
) (
  // clock and command
  input  wire logic        clk,
  input  wire logic        go,
  input  wire logic        use_pci,
  // strap resistor values
  input  wire logic [7:0]  xd,
  input  wire logic [3:0]  xa,
  input  wire logic [63:0] md,
  // reset and strap pins
  output logic             hw_reset_in,
  output logic             pci_rst_n,
  output logic [7:0]       expansion_data_pins,
  output logic [3:0]       expansion_address_pins,
  output logic [63:0]      memory_data_pins
);
  int         cnt  = 0;
  logic       kind = 1'b0;
  logic [1:0] hold = 2'b00;
  logic       drive;
  // reset pulse, held its full minimum length
  always @(posedge clk) begin
    if (go) begin
      cnt <= use_pci ? PCI_HOLD : HW_HOLD;
      kind <= use_pci;
    end else if (cnt != 0) begin
      cnt <= cnt - 1;
    end
    hold <= {hold[0], cnt != 0};
  end
  assign hw_reset_in = cnt != 0 && !kind;
  assign pci_rst_n = !(cnt != 0 && kind);
  // after the hold time other traffic owns the pins: show the inverse
  assign drive = cnt != 0 || hold != 2'b00;
  assign expansion_data_pins = drive ? xd : ~xd;
  assign expansion_address_pins = drive ? xa : ~xa;
  assign memory_data_pins = drive ? md : ~md;
endmodule : rsc_board_model
`default_nettype wire

/* tb/rsc_reset_strap_tb_top.sv */
// rsc_reset_strap_tb_top: strap decode, soft resets and register checks
// assumes the design answers apb with pready and the board model drives pins
`default_nettype none
module rsc_reset_strap_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import rsc_pkg::*;
  localparam int SOFT_HOLD = 50;  // stands in for 1 ms
  logic clk = 1'b0, sys_rst = 1'b1, go = 1'b0, use_pci = 1'b0, e;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, pready, pslverr;
  logic [7:0] paddr = 8'h00, xd = 8'h00, expansion_data_pins;
  logic [3:0] xa = 4'h0, expansion_address_pins;
  logic [31:0] pwdata = 32'h0, prdata, q, proc_pc;
  logic [63:0] md = 64'h0, memory_data_pins;
  logic hw_reset_in, pci_rst_n, core_state_rst, pci_logic_rst, fifo_flush, dcache_invalidate;
  logic dcache_enable, instruction_cache_enable, screen_refresh_en, video_out_en, mem_ctrl_init;
  logic mem_refresh_en, vga_mode, compat_mode, proc_hold, peripheral_reset_out_n;
  logic mem_clock_valid;
  logic [16:0] mem_clock_khz, proc_clock_khz;
  rsc_cfg_s cfg;
  int err_count = 0, total_checks = 0, cyc = 0;
  logic [16:0] ptab [8] = '{17'h0, KHZ_90000, KHZ_83330, KHZ_75000, KHZ_66670, KHZ_60000,
                            KHZ_55600, KHZ_50000};
  logic [16:0] mtab [4] = '{KHZ_66670, KHZ_83330, KHZ_100000, KHZ_125000};
  rsc_reset_strap dut_u (.*);
  rsc_board_model board_u (.*);
  ////////////////////////////////////////////////////////////////////////////////
  // clock and hang guard
  always #2.5 clk = ~clk;
  always @(posedge clk) begin
    cyc++;
    if (cyc > 5000) begin
      err_count++;
      $display("[FAIL] run time expected below 5000 seen %0d", cyc);
      stop_test();
    end
  end
  task stop_test;
    $display("checks %0d errors %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : stop_test
  task chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    total_checks++;
    if (got !== exp) begin
      err_count++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk
  // one apb transfer; waits for pready without assuming its delay
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r,
           output logic er);
    @(posedge clk);
    {psel, penable, pwrite, paddr, pwdata} <= {1'b1, 1'b0, w, a, d};
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    r = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  // reset pulse from the board, then wait out memory init
  task hard_reset(input logic p);
    int n;
    @(posedge clk);
    {go, use_pci} <= {1'b1, p};
    @(posedge clk);
    go <= 1'b0;
    @(posedge clk);
    n = 0;
    while (hw_reset_in || !pci_rst_n) @(posedge clk);
    while (mem_refresh_en !== 1'b1) begin
      @(posedge clk);
      n++;
    end
    chk("mem init", 32'h1, 32'(n >= MEM_INIT_CYC && n <= MEM_INIT_CYC + 4 &&
      !mem_ctrl_init));
  endtask : hard_reset
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    logic [2:0] k;
    repeat (16) @(posedge clk);
    sys_rst <= 1'b0;
    // processor codes 8 to 15, every memory rate and role code, alternating reset source
    for (int i = 0; i < 8; i++) begin
      k = 3'(i);
      xd <= {k[1:0], k[2], ~k[0], 4'(8 + i)};
      xa <= 4'(7 * i) ^ {3'h0, k[1]};
      md <= ({8{8'(37 * i)}} & ~64'h6000_0000) | (64'(k[1:0]) << 29);
      hard_reset(k[0]);
      chk("proc khz", 32'(ptab[i]), 32'(proc_clock_khz));
      chk("mem khz", {14'h0, xd[5], mtab[k[1:0]]}, {14'h0, mem_clock_valid, mem_clock_khz});
      chk("strap mem", 32'({md[30:29], md[33], md[35], md[40:38], md[43:41], md[44],
        md[62:61]}), 32'(cfg.mem));
      chk("clock cfg", {24'h0, ~xd[4], xd[5], ~xd[4] & xa[0], ~xd[4] & ~xa[0], xa[1], xa[2],
        ~xa[3], xa[3:1] == 3'h0 && xd[5]}, {24'h0, cfg.test_mode, cfg.pll_run_strap,
        cfg.dac_from_video_in, cfg.dac_from_test_counter, cfg.system_clock_from_pll,
        cfg.pixel_clock_from_pll, cfg.pll_analog_check, cfg.clock_test_state});
      chk("role", 32'({xd[7] ? 2'h2 : {1'b0, xd[6]}, xd[7], 1'b1}),
        32'({cfg.display_role, vga_mode, compat_mode}));
      apb(1'b0, OFF_STRAP_EXP, 32'h0, q, e);
      chk("strap exp", {20'h0, xa, xd}, q);
    end
    // soft reset with enables set beforehand
    apb(1'b1, OFF_CTRL, 32'h5c, q, e);
    repeat (2) @(posedge clk);
    chk("enables", 32'h1d, 32'({screen_refresh_en, video_out_en, instruction_cache_enable, compat_mode,
      dcache_enable}));
    apb(1'b1, OFF_CTRL, 32'h5d, q, e);
    repeat (3) @(posedge clk);
    chk("soft outs", 32'h16e3, 32'({core_state_rst, pci_logic_rst, peripheral_reset_out_n,
      mem_refresh_en, vga_mode, fifo_flush, dcache_invalidate, dcache_enable, instruction_cache_enable,
      screen_refresh_en, video_out_en, compat_mode, proc_hold}));
    chk("soft pc", 32'hfffffff0, proc_pc);
    apb(1'b0, OFF_CTRL, 32'h0, q, e);
    chk("ctrl in soft", 32'h1, q);
    repeat (SOFT_HOLD) @(posedge clk);
    apb(1'b1, OFF_CTRL, 32'h0, q, e);
    repeat (3) @(posedge clk);
    apb(1'b0, OFF_STRAP_EXP, 32'h0, q, e);
    chk("strap after soft", {20'h0, xa, xd}, q);
    chk("after soft", 32'h1, 32'({core_state_rst, vga_mode, mem_refresh_en}));
    // peripheral reset from software alone
    apb(1'b1, OFF_CTRL, 32'h2, q, e);
    repeat (2) @(posedge clk);
    chk("xrst soft", 32'h0, 32'({peripheral_reset_out_n, core_state_rst}));
    apb(1'b1, OFF_CTRL, 32'h0, q, e);
    repeat (2) @(posedge clk);
    chk("xrst off", 32'h1, 32'(peripheral_reset_out_n));
    // refused accesses
    apb(1'b1, OFF_STATUS, 32'hff, q, e);
    apb(1'b0, 8'h40, 32'h0, q, e);
    chk("unmapped", 32'h1, 32'({|q, e}));
    apb(1'b0, OFF_STATUS, 32'h0, q, e);
    chk("status", 32'h54, q);
    stop_test();
  end
endmodule : rsc_reset_strap_tb_top
`default_nettype wire
